// ===== hdl/uislf_pkg.sv
// uislf_pkg: shared constants for the interrupt identity and line format block
// assumes an 8-bit register port with a 4-bit address and one system clock
package uislf_pkg;
  // ==========================================================================
  // register port and offsets
  localparam int        ADDR_W       = 4;
  localparam logic [3:0] ADDR_IDENT   = 4'h0;  // interrupt_identity, read only
  localparam logic [3:0] ADDR_LINEFMT = 4'h1;  // line_format_control
  localparam logic [3:0] ADDR_FEATURE = 4'h2;  // enhanced_feature_control, latch-select only
  localparam logic [3:0] ADDR_FIFOCTL = 4'h3;  // fifo enable mirror
  localparam logic [3:0] ADDR_EVSTAT  = 4'h4;  // sticky event status, read only
  localparam logic [3:0] ADDR_EVCLR   = 4'h5;  // event clear, write one to clear
  localparam logic [3:0] ADDR_EVEN    = 4'h6;  // event enable
  localparam logic [3:0] ADDR_DIVLO   = 4'h7;  // divisor low, latch-select only
  localparam logic [3:0] ADDR_DIVHI   = 4'h8;  // divisor high, latch-select only
  // ==========================================================================
  // reset values and field positions
  localparam logic [7:0] LINEFMT_RST  = 8'h00;
  localparam logic [7:0] FEATURE_RST  = 8'h00;
  localparam logic [7:0] DIV_RST      = 8'h00;
  localparam int        LF_LATCHSEL  = 7;
  localparam int        LF_BREAK     = 6;
  localparam int        LF_STOP      = 2;
  localparam int        FE_FLOWIRQ   = 4;
  localparam int        FC_ENABLE    = 0;
  // ==========================================================================
  // identity codes, bits 5:1 plus the pending flag in bit 0
  localparam logic [5:0] ID_LINE      = 6'h06;
  localparam logic [5:0] ID_RXDATA    = 6'h04;
  localparam logic [5:0] ID_RXTO      = 6'h0C;
  localparam logic [5:0] ID_TXEMPTY   = 6'h02;
  localparam logic [5:0] ID_MODEM     = 6'h00;
  localparam logic [5:0] ID_XOFF      = 6'h10;
  localparam logic [5:0] ID_FLOW      = 6'h20;
  localparam logic [5:0] ID_NONE      = 6'h01;
  // source indices, highest priority first
  localparam int        SRC_N        = 7;
  localparam int        SRC_LINE     = 0;
  localparam int        SRC_RXTO     = 1;
  localparam int        SRC_RXDATA   = 2;
  localparam int        SRC_TXEMPTY  = 3;
  localparam int        SRC_MODEM    = 4;
  localparam int        SRC_XOFF     = 5;
  localparam int        SRC_FLOW     = 6;
  // ==========================================================================
  // event status bits
  localparam int        EV_W         = 4;
  localparam int        EV_PARERR    = 0;
  localparam int        EV_TXDONE    = 1;
  localparam int        EV_XOFF      = 2;
  localparam int        EV_FLOW      = 3;
  // ==========================================================================
  // timing: the baud generator gives a half-bit tick
  localparam logic [2:0] HALVES_BIT   = 3'h2;  // one bit time
  localparam logic [2:0] HALVES_ONEHALF = 3'h3;  // one and a half bit times
  localparam logic [2:0] HALVES_TWO   = 3'h4;  // two bit times
endpackage : uislf_pkg

// ===== hdl/uislf_prio.sv
// uislf_prio: picks the highest pending interrupt source as a one-hot vector
// assumes bit 0 of the pending vector is the most urgent source
`timescale 1ns/100ps
module uislf_prio (
  input  wire logic [uislf_pkg::SRC_N-1:0] pending,   // pending sources
  output logic      [uislf_pkg::SRC_N-1:0] winner     // one-hot highest source
);
  // ==========================================================================
  // lowest set bit isolated by two's complement, lowest index wins
  assign winner = pending & -pending;
endmodule : uislf_prio

// ===== hdl/uislf_fmt.sv
// uislf_fmt: decodes the line format into data bits, parity and stop length
// assumes data bits above the selected word length are ignored
`timescale 1ns/100ps
module uislf_fmt (
  input  wire logic [7:0] data,        // character to frame or check
  input  wire logic [5:0] fmt,         // low six line format bits
  output logic            parEnable,   // a parity bit is in the frame
  output logic            parBit,      // parity bit value for this character
  output logic      [3:0] nData,       // data bits, 5 to 8
  output logic      [2:0] stopHalves   // stop length in half bits
);
  logic [7:0] mask;                    // keeps only the used data bits
  logic       ones;                    // xor of the used data bits

  // ==========================================================================
  // word length and stop length
  always_comb begin
    case (fmt[1:0])
      2'h0: begin mask = 8'h1F; nData = 4'h5; end
      2'h1: begin mask = 8'h3F; nData = 4'h6; end
      2'h2: begin mask = 8'h7F; nData = 4'h7; end
      default: begin mask = 8'hFF; nData = 4'h8; end
    endcase
    if (!fmt[uislf_pkg::LF_STOP])
      stopHalves = uislf_pkg::HALVES_BIT;
    else if (fmt[1:0] == 2'h0)
      stopHalves = uislf_pkg::HALVES_ONEHALF;
    else
      stopHalves = uislf_pkg::HALVES_TWO;
  end

  // ==========================================================================
  // parity select; the odd and forced-one cases follow common practice
  always_comb begin
    ones      = ^(data & mask);
    parEnable = fmt[3];
    case (fmt[5:3])
      3'b001:  parBit = ~ones;
      3'b011:  parBit = ones;
      3'b101:  parBit = 1'b1;
      3'b111:  parBit = 1'b0;
      default: parBit = 1'b0;  // no parity, value unused
    endcase
  end
endmodule : uislf_fmt

// ===== hdl/uislf_core.sv
// uislf_core: interrupt identity reporting, line format control and a framer
// assumes the baud generator pulses halfTick once per half bit time, and
// that interrupt source levels come from the fifo, line and modem blocks.
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
module uislf_core (
  input  wire logic                        clk_sys,       // 20 MHz core clock
  input  wire logic                        rst,           // async, active high
  input  wire logic [uislf_pkg::ADDR_W-1:0] regAddr,      // register address
  input  wire logic [7:0]                  regWrData,     // write data
  input  wire logic                        regWr,         // write strobe
  input  wire logic                        regRd,         // read strobe
  output logic      [7:0]                  regRdData,     // read data, next cycle
  input  wire logic                        srcLineErr,    // line condition error level
  input  wire logic                        srcRxData,     // receive data available
  input  wire logic                        srcRxTimeout,  // receive timeout level
  input  wire logic                        srcTxEmpty,    // transmit holding empty
  input  wire logic                        srcModem,      // modem line change level
  input  wire logic                        xoffSeen,      // xoff match pulse
  input  wire logic                        xonSeen,       // xon match pulse
  input  wire logic                        flowChange,    // cts/rts change pulse
  input  wire logic                        halfTick,      // half bit time pulse
  input  wire logic [7:0]                  txData,        // character to send
  input  wire logic                        txValid,       // txData is offered
  output logic                             txReady,       // framer is idle
  output logic                             txOut,         // serial output
  input  wire logic [7:0]                  rxWord,        // received character
  input  wire logic                        rxParity,      // received parity bit
  input  wire logic                        rxStrobe,      // rxWord is complete
  output logic                             rxParityErr,   // last check failed
  output logic                             divLatchSel,   // divisor latch access
  output logic      [15:0]                 divisor,       // divisor latch value
  output logic                             fifoEnable,    // fifo mode selected
  output logic                             irqOut         // level interrupt
);
  import uislf_pkg::*;

  // ==========================================================================
  // register storage
  logic [7:0]       lineFmt_reg;    // line_format_control
  logic [7:0]       feature_reg;    // enhanced_feature_control
  logic             fifoEn_reg;     // fifo enable mirror
  logic [15:0]      div_reg;        // divisor latch
  logic [EV_W-1:0]  evStat_reg;     // sticky events
  logic [EV_W-1:0]  evEn_reg;       // event enables
  logic [7:0]       rdData_reg;     // registered read answer
  logic             xoffFlag_reg;   // xoff pending until xon
  logic             flowFlag_reg;   // flow change pending until read
  logic [SRC_N-1:0] held_reg;       // source now being reported
  logic             parErr_reg;     // last receive parity result

  logic             latchSel;       // divisor and feature window open
  logic [SRC_N-1:0] pending;        // all pending sources
  logic [SRC_N-1:0] winner;         // highest pending source
  logic [SRC_N-1:0] held_next;      // reported source next cycle
  logic [5:0]       idCode;         // identity bits 5:0
  logic [7:0]       identity;       // full identity byte
  logic             identRd;        // identity register read
  logic [EV_W-1:0]  evSet;          // event pulses this cycle
  logic [EV_W-1:0]  evClr;          // software clear this cycle

  assign latchSel = lineFmt_reg[LF_LATCHSEL];
  assign identRd  = regRd && (regAddr == ADDR_IDENT);

  // ==========================================================================
  // software writes
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lineFmt_reg <= LINEFMT_RST;
      feature_reg <= FEATURE_RST;
      fifoEn_reg  <= 1'b0;
      div_reg     <= {DIV_RST, DIV_RST};
      evEn_reg    <= '0;
    end else if (regWr) begin
      case (regAddr)
        ADDR_LINEFMT: lineFmt_reg <= regWrData;
        ADDR_FIFOCTL: fifoEn_reg  <= regWrData[FC_ENABLE];
        ADDR_EVEN:    evEn_reg    <= regWrData[EV_W-1:0];
        // these three only answer with the latch window open
        ADDR_FEATURE: if (latchSel) feature_reg <= regWrData;
        ADDR_DIVLO:   if (latchSel) div_reg[7:0] <= regWrData;
        ADDR_DIVHI:   if (latchSel) div_reg[15:8] <= regWrData;
        default: ;  // unmapped or read-only: ignored
      endcase
    end
  end

  // ==========================================================================
  // flow flags for the two lowest sources
  // xoff is cleared only by xon, never by a read; a same-cycle xoff wins
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      xoffFlag_reg <= 1'b0;
    end else if (xoffSeen) begin
      xoffFlag_reg <= 1'b1;
    end else if (xonSeen) begin
      xoffFlag_reg <= 1'b0;
    end
  end

  // flow change is serviced by reading the identity while it is reported
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flowFlag_reg <= 1'b0;
    end else if (flowChange) begin
      flowFlag_reg <= 1'b1;
    end else if (identRd && held_reg[SRC_FLOW]) begin
      flowFlag_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // priority selection and hold
  always_comb begin
    pending           = '0;
    pending[SRC_LINE]    = srcLineErr;
    pending[SRC_RXTO]    = srcRxTimeout;
    pending[SRC_RXDATA]  = srcRxData;
    pending[SRC_TXEMPTY] = srcTxEmpty;
    pending[SRC_MODEM]   = srcModem;
    // lowest two levels report only with the feature bit set
    pending[SRC_XOFF]    = xoffFlag_reg & feature_reg[FE_FLOWIRQ];
    pending[SRC_FLOW]    = flowFlag_reg & feature_reg[FE_FLOWIRQ];
  end

  uislf_prio u_prio (
    .pending (pending),
    .winner  (winner)
  );

  // a held source stays while it pends, even under a higher one
  always_comb begin
    if ((held_reg & pending) != '0)
      held_next = held_reg;
    else
      held_next = winner;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      held_reg <= '0;
    end else begin
      held_reg <= held_next;
    end
  end

  // ==========================================================================
  // identity byte from the held source
  always_comb begin
    case (held_reg)
      7'b0000001: idCode = ID_LINE;
      7'b0000010: idCode = ID_RXTO;
      7'b0000100: idCode = ID_RXDATA;
      7'b0001000: idCode = ID_TXEMPTY;
      7'b0010000: idCode = ID_MODEM;
      7'b0100000: idCode = ID_XOFF;
      7'b1000000: idCode = ID_FLOW;
      default:    idCode = ID_NONE;  // nothing pending: bit 0 high
    endcase
    identity = {fifoEn_reg, fifoEn_reg, idCode};
  end

  // ==========================================================================
  // read answer, one cycle after the strobe
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdData_reg <= 8'h00;
    end else if (regRd) begin
      case (regAddr)
        ADDR_IDENT:   rdData_reg <= identity;
        ADDR_LINEFMT: rdData_reg <= lineFmt_reg;
        ADDR_FIFOCTL: rdData_reg <= {7'h00, fifoEn_reg};
        ADDR_EVSTAT:  rdData_reg <= {4'h0, evStat_reg};
        ADDR_EVEN:    rdData_reg <= {4'h0, evEn_reg};
        ADDR_FEATURE: rdData_reg <= latchSel ? feature_reg : 8'h00;
        ADDR_DIVLO:   rdData_reg <= latchSel ? div_reg[7:0] : 8'h00;
        ADDR_DIVHI:   rdData_reg <= latchSel ? div_reg[15:8] : 8'h00;
        default:      rdData_reg <= 8'h00;  // unmapped reads zero
      endcase
    end else begin
      rdData_reg <= 8'h00;
    end
  end

  // ==========================================================================
  // transmit framer
  typedef enum logic [4:0] {
    TX_IDLE  = 5'b00001,
    TX_START = 5'b00010,
    TX_DATA  = 5'b00100,
    TX_PAR   = 5'b01000,
    TX_STOP  = 5'b10000
  } uislf_tx_t;

  uislf_tx_t  txState_reg;   // framer state
  logic [7:0] txShift_reg;   // data bits, lsb first
  logic [3:0] txLeft_reg;    // data bits still to send
  logic [2:0] txHalf_reg;    // half bits spent in this slot
  logic       txParEn_reg;   // frame has a parity bit
  logic       txPar_reg;     // parity bit value
  logic [2:0] txStop_reg;    // stop length in halves
  logic       txLine_reg;    // framed line level
  logic       txDone;        // frame finished pulse
  logic       txParEn;       // format decode for the offered char
  logic       txPar;
  logic [3:0] txN;
  logic [2:0] txStop;

  uislf_fmt u_txfmt (
    .data       (txData),
    .fmt        (lineFmt_reg[5:0]),
    .parEnable  (txParEn),
    .parBit     (txPar),
    .nData      (txN),
    .stopHalves (txStop)
  );

  assign txReady = (txState_reg == TX_IDLE);
  assign txDone  = (txState_reg == TX_STOP) && halfTick && (txHalf_reg + 3'h1 == txStop_reg);

  // format is captured with the character so a mid-frame write is harmless
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      txState_reg <= TX_IDLE;
      txShift_reg <= 8'h00;
      txLeft_reg  <= 4'h0;
      txHalf_reg  <= 3'h0;
      txParEn_reg <= 1'b0;
      txPar_reg   <= 1'b0;
      txStop_reg  <= HALVES_BIT;
      txLine_reg  <= 1'b1;
    end else begin
      case (txState_reg)
        TX_IDLE: begin
          txLine_reg <= 1'b1;
          if (txValid) begin
            txShift_reg <= txData;
            txLeft_reg  <= txN;
            txParEn_reg <= txParEn;
            txPar_reg   <= txPar;
            txStop_reg  <= txStop;
            txHalf_reg  <= 3'h0;
            txLine_reg  <= 1'b0;
            txState_reg <= TX_START;
          end
        end
        TX_START, TX_DATA, TX_PAR: begin
          if (halfTick) begin
            if (txHalf_reg == 3'h0) begin
              txHalf_reg <= 3'h1;
            end else begin
              txHalf_reg <= 3'h0;
              if (txLeft_reg != 4'h0) begin
                txLine_reg  <= txShift_reg[0];
                txShift_reg <= {1'b0, txShift_reg[7:1]};
                txLeft_reg  <= txLeft_reg - 4'h1;
                txState_reg <= TX_DATA;
              end else if (txParEn_reg && txState_reg != TX_PAR) begin
                txLine_reg  <= txPar_reg;
                txState_reg <= TX_PAR;
              end else begin
                txLine_reg  <= 1'b1;
                txState_reg <= TX_STOP;
              end
            end
          end
        end
        TX_STOP: begin
          if (txDone) begin
            txState_reg <= TX_IDLE;
          end else if (halfTick) begin
            txHalf_reg <= txHalf_reg + 3'h1;
          end
        end
        default: txState_reg <= TX_IDLE;
      endcase
    end
  end

  // break overrides the framer for as long as the bit stays set
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      txOut <= 1'b1;
    end else begin
      txOut <= lineFmt_reg[LF_BREAK] ? 1'b0 : txLine_reg;
    end
  end

  // ==========================================================================
  // receive parity check with the same format decode
  logic       rxParEn;
  logic       rxPar;
  logic       rxBad;

  uislf_fmt u_rxfmt (
    .data       (rxWord),
    .fmt        (lineFmt_reg[5:0]),
    .parEnable  (rxParEn),
    .parBit     (rxPar),
    .nData      (),
    .stopHalves ()
  );

  assign rxBad = rxStrobe && rxParEn && (rxParity != rxPar);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      parErr_reg <= 1'b0;
    end else if (rxStrobe) begin
      parErr_reg <= rxBad;
    end
  end

  // ==========================================================================
  // sticky events; a set in the clear cycle survives
  always_comb begin
    evSet            = '0;
    evSet[EV_PARERR] = rxBad;
    evSet[EV_TXDONE] = txDone;
    evSet[EV_XOFF]   = xoffSeen;
    evSet[EV_FLOW]   = flowChange;
    evClr = (regWr && regAddr == ADDR_EVCLR) ? regWrData[EV_W-1:0] : '0;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      evStat_reg <= '0;
    end else begin
      evStat_reg <= (evStat_reg & ~evClr) | evSet;
    end
  end

  // ==========================================================================
  // outputs
  assign regRdData   = rdData_reg;
  assign rxParityErr = parErr_reg;
  assign divLatchSel = latchSel;
  assign divisor     = div_reg;
  assign fifoEnable  = fifoEn_reg;
  assign irqOut      = |(evStat_reg & evEn_reg);
endmodule : uislf_core

// ===== dv/uislf_checker.sv
// uislf_checker: port-level properties of uislf_core
// bound onto uislf_core; one clock domain
`timescale 1ns/100ps
module uislf_checker (
  input logic        clk_sys,
  input logic        rst,
  input logic [3:0]  regAddr,
  input logic [7:0]  regWrData,
  input logic        regWr,
  input logic        regRd,
  input logic [7:0]  regRdData,
  input logic        srcLineErr,
  input logic        txValid,
  input logic        txReady,
  input logic        txOut,
  input logic        rxStrobe,
  input logic        rxParityErr,
  input logic        divLatchSel,
  input logic [15:0] divisor,
  input logic        fifoEnable
);
  // ==========================================================================
  // line format shadow from bus writes
  logic [7:0] fmtReg;  // last written line format
  logic       idRd;    // identity read strobe
  assign idRd = regRd && regAddr == uislf_pkg::ADDR_IDENT;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) fmtReg <= 8'h00;
    else if (regWr && regAddr == uislf_pkg::ADDR_LINEFMT) fmtReg <= regWrData;
  end
  // ==========================================================================
  // properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_rd_idle: assert property (!$past(regRd) |-> regRdData == 8'h00)
    else $error("read data not idle");
  a_fifo_bits: assert property ($past(idRd) |-> regRdData[7:6] == {2{$past(fifoEnable)}})
    else $error("fifo bits wrong");
  a_pend_flag: assert property ($past(idRd && srcLineErr) && $past(srcLineErr, 2)
    |-> !regRdData[0]) else $error("pending flag wrong");
  a_code_legal: assert property ($past(idRd) |-> regRdData[5:0] inside {6'h06, 6'h04,
    6'h0C, 6'h02, 6'h00, 6'h10, 6'h20, 6'h01}) else $error("identity code illegal");
  a_break_hold: assert property (fmtReg[6] && $past(fmtReg[6]) |-> !txOut)
    else $error("break not held");
  a_tx_start: assert property (txValid && txReady |-> ##3 !txOut)
    else $error("start bit missing");
  a_tx_busy: assert property (txValid && txReady |=> !txReady [*2])
    else $error("framer not busy");
  a_latch_sel: assert property ($past(regWr && regAddr == uislf_pkg::ADDR_LINEFMT)
    |-> divLatchSel == $past(regWrData[7])) else $error("latch select wrong");
  a_div_gate: assert property (regWr && !divLatchSel && regAddr inside {4'h7, 4'h8}
    |=> $stable(divisor)) else $error("divisor written while closed");
  a_nopar_ok: assert property (rxStrobe && !fmtReg[3] |=> !rxParityErr)
    else $error("parity error without parity");
endmodule : uislf_checker

// ===== dv/uislf_remote_rx.sv
// uislf_remote_rx: remote receiver sampling the serial output mid-bit
// assumes nBits is set before a frame
`timescale 1ns/100ps
module uislf_remote_rx (
  input  logic        clk_sys,
  input  logic        rst,
  input  logic        txOut,
  input  logic        halfTick,
  input  logic [3:0]  nBits,   // start, data and parity bits to take
  output logic [11:0] bits     // samples, newest at the top
);
  logic       busy;  // inside a frame
  logic [4:0] cnt;   // half bits seen
  logic [3:0] got;   // samples taken
  // sample on every odd half bit, so edges never race the sample
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
      cnt  <= 5'h00;
      got  <= 4'h0;
      bits <= 12'h000;
    end else if (!busy) begin
      busy <= !txOut && got == 4'h0;
      cnt  <= 5'h00;
      if (txOut) got <= 4'h0;
    end else if (halfTick) begin
      cnt <= cnt + 5'h01;
      if (!cnt[0]) begin
        bits <= {txOut, bits[11:1]};     // lsb first
        got  <= got + 4'h1;
        busy <= (got + 4'h1 != nBits);   // start bit, word length and parity
      end
    end
  end
endmodule : uislf_remote_rx

// ===== dv/uislf_tb.sv
// uislf_tb: bench for uislf_core
// assumes the model and checker are compiled too
`timescale 1ns/100ps
module testbench;
  logic clk_sys = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0, halfTick = 1'b0;
  logic txValid = 1'b0, rxParity = 1'b0, rxStrobe = 1'b0;
  logic txReady, txOut, rxParityErr, divLatchSel, fifoEnable, irqOut;
  logic [3:0]  regAddr = 4'h0, pNb = 4'hA;
  logic [7:0]  regWrData = 8'h00, txData = 8'h00, rxWord = 8'h00, regRdData;
  logic [4:0]  src = 5'h00;   // line, timeout, rx data, tx empty, modem
  logic [2:0]  ev = 3'h0;     // flow, xon, xoff pulses
  logic [1:0]  hq = 2'h0;
  logic [11:0] pBits;
  logic [15:0] divisor, r = 16'hDED2;
  int err_total = 0, comparisons = 0, hc, k, i;
  // ==========================================================================
  // clock and a half-bit tick every fourth cycle
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    hq <= hq + 2'h1;
    halfTick <= (hq == 2'h3);
  end
  uislf_core i_uislf_core (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .srcLineErr(src[4]), .srcRxTimeout(src[3]), .srcRxData(src[2]), .srcTxEmpty(src[1]),
    .srcModem(src[0]), .xoffSeen(ev[0]), .xonSeen(ev[1]), .flowChange(ev[2]),
    .halfTick(halfTick), .txData(txData), .txValid(txValid), .txReady(txReady), .txOut(txOut),
    .rxWord(rxWord), .rxParity(rxParity), .rxStrobe(rxStrobe), .rxParityErr(rxParityErr),
    .divLatchSel(divLatchSel), .divisor(divisor), .fifoEnable(fifoEnable), .irqOut(irqOut));
  uislf_remote_rx i_uislf_remote_rx (.clk_sys(clk_sys), .rst(rst), .txOut(txOut),
    .halfTick(halfTick), .nBits(pNb), .bits(pBits));
  // ==========================================================================
  // expectations
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    lfsr = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr
  function automatic logic parb(input logic [7:0] d, input logic [5:0] f);
    logic [7:0] m;
    m = d & (8'hFF >> (2'h3 - f[1:0]));
    parb = f[4] ? (f[5] ? 1'b0 : ^m) : (f[5] ? 1'b1 : ~^m);
  endfunction : parb
  function automatic logic [5:0] code(input logic [4:0] s);
    code = s[4] ? 6'h06 : s[3] ? 6'h0C : s[2] ? 6'h04 : s[1] ? 6'h02 : s[0] ? 6'h00 : 6'h01;
  endfunction : code
  // ==========================================================================
  // bus cycles and compare
  task automatic complete_run;
    if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys) {regWr, regAddr, regWrData} <= {1'b1, a, d};
    @(posedge clk_sys) regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys) {regRd, regAddr} <= {1'b1, a};
    @(posedge clk_sys) regRd <= 1'b0;
    @(negedge clk_sys) chk(regRdData, e);
  endtask : rd
  task automatic pls(input logic [2:0] v);
    @(posedge clk_sys) ev <= v;
    @(posedge clk_sys) ev <= 3'h0;
  endtask : pls
  task automatic sw(input logic [4:0] s);
    src <= s;
    repeat (3) @(posedge clk_sys);
  endtask : sw
  task automatic rxc(input logic [7:0] w, input logic p);
    @(posedge clk_sys) {rxWord, rxParity, rxStrobe} <= {w, p, 1'b1};
    @(posedge clk_sys) rxStrobe <= 1'b0;
    @(negedge clk_sys);
  endtask : rxc
  // ==========================================================================
  // main sequence
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    rd(4'h0, 8'h01);
    rd(4'h1, 8'h00);
    wr(4'h1, 8'h80);
    wr(4'h7, 8'h5A);
    wr(4'h8, 8'hC3);
    wr(4'h2, 8'h10);
    rd(4'h7, 8'h5A);
    wr(4'h1, 8'h00);
    wr(4'h7, 8'h11);
    rd(4'h7, 8'h00);
    chk(divisor, 16'hC35A);
    rd(4'hF, 8'h00);
    for (i = 0; i < 40; i++) begin
      r = lfsr(r);
      src <= 5'h00;
      wr(4'h3, {7'h00, r[8]});
      sw(r[4:0]);
      rd(4'h0, {{2{r[8]}}, code(r[4:0])});
    end
    wr(4'h3, 8'h00);
    sw(5'h02);
    sw(5'h12);
    rd(4'h0, 8'h02);
    sw(5'h10);
    rd(4'h0, 8'h06);
    src <= 5'h00;
    pls(3'h1);
    rd(4'h0, 8'h10);
    rd(4'h0, 8'h10);
    pls(3'h2);
    rd(4'h0, 8'h01);
    pls(3'h4);
    rd(4'h0, 8'h20);
    rd(4'h0, 8'h01);
    wr(4'h1, 8'h80);
    wr(4'h2, 8'h00);
    wr(4'h1, 8'h00);
    pls(3'h1);
    rd(4'h0, 8'h01);
    for (i = 0; i < 24; i++) begin
      r = lfsr(r);
      wr(4'h1, {2'h0, r[5:0]});
      pNb <= 4'h6 + r[1:0] + r[3];
      for (k = 0; k < 8 && !halfTick; k++) @(posedge clk_sys);
      {txData, txValid} <= {r[15:8], 1'b1};
      @(posedge clk_sys) txValid <= 1'b0;
      hc = 0;
      for (k = 0; k < 400; k++) begin
        @(posedge clk_sys);
        if (txReady === 1'b1) break;
        if (halfTick) hc++;
      end
      if (k == 400) begin
        err_total++;
        complete_run();
      end
      chk(16'(hc), 16'(2 * pNb + (r[2] ? (r[1:0] == 2'h0 ? 3 : 4) : 2)));
      chk(16'(pBits >> (12 - pNb)),
        {7'h00, r[15:8] & (8'hFF >> (2'h3 - r[1:0])), 1'b0} |
        (16'(parb(r[15:8], r[5:0]) & r[3]) << (6 + r[1:0])));
      rxc(r[15:8], r[6]);
      chk(rxParityErr, r[3] && (r[6] != parb(r[15:8], r[5:0])));
    end
    wr(4'h1, 8'h40);
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys) chk(txOut, 1'b0);
    repeat (30) @(posedge clk_sys);
    @(negedge clk_sys) chk(txOut, 1'b0);
    wr(4'h1, 8'h08);
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys) chk(txOut, 1'b1);
    wr(4'h5, 8'h0F);
    wr(4'h6, 8'h01);
    rxc(8'h00, 1'b0);
    chk(irqOut, 1'b1);
    rd(4'h4, 8'h01);
    wr(4'h6, 8'h00);
    @(negedge clk_sys) chk(irqOut, 1'b0);
    wr(4'h5, 8'h01);
    wr(4'h6, 8'h01);
    @(negedge clk_sys) chk(irqOut, 1'b0);
    complete_run();
  end
endmodule : testbench
bind uislf_core uislf_checker i_uislf_checker (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
  .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
  .srcLineErr(srcLineErr), .txValid(txValid), .txReady(txReady), .txOut(txOut),
  .rxStrobe(rxStrobe), .rxParityErr(rxParityErr), .divLatchSel(divLatchSel),
  .divisor(divisor), .fifoEnable(fifoEnable));
